//--- inc/dsl_pkg.sv
// Shared constants, register map and carrier types of the drive service-data logger.
// Assumes a single 50 MHz clock; all times are derived from it by dividers.
`default_nettype none
package dsl_pkg;
  localparam int DSL_CLK_KHZ = 50000;
  localparam int DSL_TICK_MS = 10;
  localparam int DSL_SNAP_MS = 160;
  localparam int DSL_TENTH_HOUR_MS = 360000;
  localparam int DSL_SNAP_TICKS = DSL_SNAP_MS / DSL_TICK_MS;
  localparam int DSL_TENTHS_PER_HOUR = 10;
  localparam int DSL_LOG_DEPTH = 20;
  localparam int DSL_TRIP_DEPTH = 10;
  localparam logic [31:0] DSL_HOURS_MAX = 32'h0013_d620;
  localparam logic [31:0] DSL_EVENT_MAX = 32'h0000_270f;
  localparam logic [31:0] DSL_ENERGY_MAX = 32'hffff_ffff;
  localparam logic [6:0] DSL_CODE_MAX = 7'h63;
  localparam logic [13:0] DSL_TVAL_MAX = 14'h270f;
  localparam logic [2:0] DSL_OVOLT_ALARM = 3'h7;
  // Register word offsets (byte address = offset)
  localparam logic [7:0] DSL_R_OPHOURS = 8'h00;
  localparam logic [7:0] DSL_R_RUNHOURS = 8'h04;
  localparam logic [7:0] DSL_R_ENERGY = 8'h08;
  localparam logic [7:0] DSL_R_CUTINS = 8'h0c;
  localparam logic [7:0] DSL_R_OVTEMPS = 8'h10;
  localparam logic [7:0] DSL_R_OVVOLTS = 8'h14;
  localparam logic [7:0] DSL_R_CMDWORD = 8'h18;
  localparam logic [7:0] DSL_R_LOGIDX = 8'h1c;
  localparam logic [7:0] DSL_R_TRIPIDX = 8'h20;
  localparam logic [7:0] DSL_R_CLRSEL = 8'h24;
  localparam logic [7:0] DSL_R_LOG_INP = 8'h28;
  localparam logic [7:0] DSL_R_LOG_CMD = 8'h2c;
  localparam logic [7:0] DSL_R_LOG_STATE = 8'h30;
  localparam logic [7:0] DSL_R_LOG_REF = 8'h34;
  localparam logic [7:0] DSL_R_LOG_FB = 8'h38;
  localparam logic [7:0] DSL_R_LOG_FREQ = 8'h3c;
  localparam logic [7:0] DSL_R_LOG_VOLT = 8'h40;
  localparam logic [7:0] DSL_R_LOG_CURR = 8'h44;
  localparam logic [7:0] DSL_R_LOG_DC = 8'h48;
  localparam logic [7:0] DSL_R_TRIP_CODE = 8'h4c;
  localparam logic [7:0] DSL_R_TRIP_TIME = 8'h50;
  localparam logic [7:0] DSL_R_TRIP_VAL = 8'h54;
  localparam logic [7:0] DSL_R_STATUS = 8'h58;
  localparam logic [4:0] DSL_LOGIDX_RST = 5'h01;
  localparam logic [3:0] DSL_TRIPIDX_RST = 4'h1;
  localparam logic [15:0] DSL_CMD_RST = 16'h0000;

  typedef enum logic [1:0] {DSL_IDLE = 2'b00, DSL_RUN = 2'b01, DSL_FROZEN = 2'b11} dsl_state_t;

  // Digital inputs: bit 7 = terminal 16 ... bit 0 = terminal 33
  typedef struct packed {
    logic [7:0] digIn;
    logic [15:0] stateWord;
    logic [6:0] refPct;
    logic [31:0] feedback;
    logic [15:0] outFreq;
    logic [15:0] outVolt;
    logic [15:0] outCurr;
    logic [15:0] dcLink;
  } dsl_sample_t;

  typedef struct packed {
    dsl_sample_t smp;
    logic [15:0] cmdWord;
  } dsl_entry_t;

  typedef struct packed {
    logic [6:0] code;
    logic [31:0] runHours;
    logic [13:0] value;
  } dsl_trip_t;
endpackage
`default_nettype wire

//--- verilog/dsl_tick_div.sv
// Enabled divider: one-cycle tick every DIV enabled cycles.
// Assumes en is synchronous to ref_clk.
`default_nettype none
module dsl_tick_div #(
  parameter int DIV = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic en,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;
  wire atLast = (cnt == LAST);
  generate
    if (DIV < 1)
    begin : g_chk
      $error("dsl_tick_div: DIV must be at least 1");
    end
  endgenerate
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= en & atLast;
      if (en)
        cnt <= atLast ? '0 : cnt + CW'(1);
    end
  end
endmodule
`default_nettype wire

//--- verilog/dsl_logger.sv
// Service-data logger top: lifetime counters, snapshot log, trip history, AHB-Lite slave.
// Assumes event inputs are one-cycle pulses synchronous to ref_clk and a single bus master.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none
//
// Contract
// RULE1: Powered hours counted to 130000.0, saved hourly and at power loss, never cleared.
// RULE2: Motor-run hours counted since last clear, saved hourly and at power loss.
// RULE3: Energy accumulates hourly mean output power; clearable by energy clear.
// RULE4: Supply cut-ins counted within 0 to 9999.
// RULE5: Heat-sink over-temperature events counted within 0 to 9999.
// RULE6: Over-voltage events counted only while alarm 7 active, 0 to 9999.
// RULE7: Snapshot log holds 20 entries, index 1 newest, 20 oldest.
// RULE8: After start, new snapshot every 160 ms, older entries shift toward oldest.
// RULE9: Trip or motor stop halts capture and keeps the 20 latest entries.
// RULE10: Logged input byte: terminals 16..33 map to bit weights 128 down to 1.
// RULE11: Snapshot holds 16-bit command word, changeable only over the serial link.
// RULE12: Snapshot holds the 16-bit drive state word.
// RULE13: Snapshot holds reference, feedback, frequency, voltage, current, DC-link voltage.
// RULE14: Trip history stores cause codes 0..99 for ten trips, 1 newest.
// RULE15: Each trip entry stores run hours at the moment of that trip.
// RULE16: Each trip entry stores a value 0..9999 whose unit follows the code.
// RULE17: Trip history cleared only by manual initialization.
// RULE18: Energy clear select 1 plus panel confirm zeroes energy; 0 means no clear.
// RULE19: Energy clear select cannot be set through the serial port.
// RULE20: All lifetime counters readable on the panel display and the serial port.
// RULE21: Run-hour clear select 1 plus panel confirm zeroes run hours.
// RULE22: Event counters saturate at their maximum instead of wrapping.
module dsl_logger
  import dsl_pkg::*;
#(
  parameter int BASE_CYCLES = DSL_TICK_MS * DSL_CLK_KHZ,
  parameter int TENTH_TICKS = DSL_TENTH_HOUR_MS / DSL_TICK_MS,
  parameter int LOG_DEPTH = DSL_LOG_DEPTH,
  parameter int TRIP_DEPTH = DSL_TRIP_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic motorRun,
  input wire logic startCmd,
  input wire logic powerFail,
  input wire logic supplyCutIn,
  input wire logic overTemp,
  input wire logic overVolt,
  input wire logic [2:0] alarmActive,
  input wire logic [15:0] outPowerW,
  input wire dsl_sample_t sample,
  input wire logic tripEvt,
  input wire logic [6:0] tripCodeIn,
  input wire logic [13:0] tripValueIn,
  input wire logic manualInit,
  input wire logic panelSelWr,
  input wire logic panelSelRun,
  input wire logic panelSelVal,
  input wire logic panelOk,
  input wire logic [7:0] panelAddr,
  input wire logic [4:0] panelLogIdx,
  input wire logic [3:0] panelTripIdx,
  output logic [31:0] panelData,
  output logic [15:0] cmdWordOut,
  output logic nvSave,
  output logic logging
);
  generate
    if (LOG_DEPTH < 1 || LOG_DEPTH > 31 || TRIP_DEPTH < 1 || TRIP_DEPTH > 15 || TENTH_TICKS < 1)
    begin : g_chk
      $error("dsl_logger: depth or tick parameter out of range");
    end
  endgenerate

  logic [31:0] opHours, runHours, energy, cutIns, ovTemps, ovVolts, powerSum;
  logic [3:0] hourPhase, runPhase;
  logic [15:0] cmdWord;
  logic [4:0] logIdx;
  logic [3:0] tripIdx;
  logic energySel, runSel;
  dsl_state_t state, next_state;
  dsl_entry_t logMem [LOG_DEPTH];
  dsl_trip_t tripMem [TRIP_DEPTH];
  logic aWr, aRd;
  logic [7:0] aAddr;

  wire baseTick, snapTick, tenthTick, runTenthTick;
  dsl_tick_div #(.DIV(BASE_CYCLES)) u_base (.ref_clk(ref_clk), .srst(srst), .en(1'b1), .tick(baseTick));
  dsl_tick_div #(.DIV(DSL_SNAP_TICKS)) u_snap (.ref_clk(ref_clk), .srst(srst),
    .en(baseTick & (state == DSL_RUN)), .tick(snapTick));
  dsl_tick_div #(.DIV(TENTH_TICKS)) u_tenth (.ref_clk(ref_clk), .srst(srst), .en(baseTick), .tick(tenthTick));
  dsl_tick_div #(.DIV(TENTH_TICKS)) u_runt (.ref_clk(ref_clk), .srst(srst),
    .en(baseTick & motorRun), .tick(runTenthTick));

  function automatic logic [31:0] satInc(input logic [31:0] v, input logic [31:0] lim);
    satInc = (v < lim) ? v + 32'h1 : v;
  endfunction

  // Shared by the bus and the panel display so both views agree on every word except log and trip entries, which follow separate indexes
  function automatic logic [31:0] regRead(input logic [7:0] a, input logic [4:0] li, input logic [3:0] ti);
    dsl_entry_t e;
    dsl_trip_t t;
    logic [4:0] lp;
    logic [3:0] tp;
    lp = (li >= 5'h1 && li <= 5'(LOG_DEPTH)) ? li - 5'h1 : 5'h0;
    tp = (ti >= 4'h1 && ti <= 4'(TRIP_DEPTH)) ? ti - 4'h1 : 4'h0;
    e = logMem[lp];
    t = tripMem[tp];
    case (a)
      DSL_R_OPHOURS: regRead = opHours;
      DSL_R_RUNHOURS: regRead = runHours;
      DSL_R_ENERGY: regRead = energy;
      DSL_R_CUTINS: regRead = cutIns;
      DSL_R_OVTEMPS: regRead = ovTemps;
      DSL_R_OVVOLTS: regRead = ovVolts;
      DSL_R_CMDWORD: regRead = {16'h0, cmdWord};
      DSL_R_LOGIDX: regRead = {27'h0, logIdx};
      DSL_R_TRIPIDX: regRead = {28'h0, tripIdx};
      DSL_R_CLRSEL: regRead = {30'h0, runSel, energySel};
      DSL_R_LOG_INP: regRead = {24'h0, e.smp.digIn};
      DSL_R_LOG_CMD: regRead = {16'h0, e.cmdWord};
      DSL_R_LOG_STATE: regRead = {16'h0, e.smp.stateWord};
      DSL_R_LOG_REF: regRead = {25'h0, e.smp.refPct};
      DSL_R_LOG_FB: regRead = e.smp.feedback;
      DSL_R_LOG_FREQ: regRead = {16'h0, e.smp.outFreq};
      DSL_R_LOG_VOLT: regRead = {16'h0, e.smp.outVolt};
      DSL_R_LOG_CURR: regRead = {16'h0, e.smp.outCurr};
      DSL_R_LOG_DC: regRead = {16'h0, e.smp.dcLink};
      DSL_R_TRIP_CODE: regRead = {25'h0, t.code};
      DSL_R_TRIP_TIME: regRead = t.runHours;
      DSL_R_TRIP_VAL: regRead = {18'h0, t.value};
      DSL_R_STATUS: regRead = {30'h0, state};
      default: regRead = 32'h0;
    endcase
  endfunction

  // Bus decode: zero-wait slave, so hready equals our own hreadyout
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] busAddr = haddr[7:0];
  logic [31:0] busRead;
  always_comb busRead = regRead(busAddr, logIdx, tripIdx);
  wire wrCmd = aWr & (aAddr == DSL_R_CMDWORD);
  wire wrLogIdx = aWr & (aAddr == DSL_R_LOGIDX) & (hwdata[4:0] >= 5'h1) & (hwdata[4:0] <= 5'(LOG_DEPTH));
  wire wrTripIdx = aWr & (aAddr == DSL_R_TRIPIDX) & (hwdata[3:0] >= 4'h1) & (hwdata[3:0] <= 4'(TRIP_DEPTH));
  wire hourTick = tenthTick & (hourPhase == 4'(DSL_TENTHS_PER_HOUR - 1));
  wire energyClr = panelOk & energySel;
  wire runClr = panelOk & runSel;
  wire ovEvent = overVolt & (alarmActive == DSL_OVOLT_ALARM);
  wire capture = snapTick & (state == DSL_RUN);
  wire [31:0] hourMean = (powerSum + {16'h0, outPowerW}) / 32'(DSL_TENTHS_PER_HOUR);
  wire [6:0] codeSat = (tripCodeIn > DSL_CODE_MAX) ? DSL_CODE_MAX : tripCodeIn;
  wire [13:0] valSat = (tripValueIn > DSL_TVAL_MAX) ? DSL_TVAL_MAX : tripValueIn;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      aWr <= 1'b0;
      aRd <= 1'b0;
      aAddr <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      aWr <= addrPhase & hwrite;
      aRd <= addrPhase & ~hwrite;
      aAddr <= busAddr;
      hrdata <= (addrPhase & ~hwrite) ? busRead : 32'h0; // [RULE20]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cmdWord <= DSL_CMD_RST;
      logIdx <= DSL_LOGIDX_RST;
      tripIdx <= DSL_TRIPIDX_RST;
      cmdWordOut <= DSL_CMD_RST;
      panelData <= 32'h0;
    end
    else
    begin
      if (wrCmd)
        cmdWord <= hwdata[15:0]; // [RULE11]
      if (wrLogIdx)
        logIdx <= hwdata[4:0];
      if (wrTripIdx)
        tripIdx <= hwdata[3:0];
      cmdWordOut <= wrCmd ? hwdata[15:0] : cmdWord;
      panelData <= regRead(panelAddr, panelLogIdx, panelTripIdx); // [RULE20]
    end
  end

  // Clear selects are panel-only; a bus write to their word is ignored
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      energySel <= 1'b0;
      runSel <= 1'b0;
    end
    else if (panelSelWr)
    begin
      if (panelSelRun)
        runSel <= panelSelVal;
      else
        energySel <= panelSelVal; // [RULE19]
    end
    else if (panelOk)
    begin
      energySel <= 1'b0;
      runSel <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      opHours <= 32'h0;
      runHours <= 32'h0;
      hourPhase <= 4'h0;
      runPhase <= 4'h0;
      nvSave <= 1'b0;
    end
    else
    begin
      if (tenthTick)
      begin
        opHours <= satInc(opHours, DSL_HOURS_MAX); // [RULE1] [RULE22]
        hourPhase <= hourTick ? 4'h0 : hourPhase + 4'h1;
      end
      // A tick in the clearing cycle is kept, not lost
      if (runClr)
        runHours <= runTenthTick ? 32'h1 : 32'h0; // [RULE21]
      else if (runTenthTick)
        runHours <= satInc(runHours, DSL_HOURS_MAX); // [RULE2]
      if (runTenthTick)
        runPhase <= (runPhase == 4'(DSL_TENTHS_PER_HOUR - 1)) ? 4'h0 : runPhase + 4'h1;
      nvSave <= hourTick | powerFail | (runTenthTick & (runPhase == 4'(DSL_TENTHS_PER_HOUR - 1))); // [RULE1] [RULE2]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      energy <= 32'h0;
      powerSum <= 32'h0;
    end
    else
    begin
      if (tenthTick)
        powerSum <= hourTick ? 32'h0 : powerSum + {16'h0, outPowerW};
      if (energyClr)
        energy <= hourTick ? hourMean : 32'h0; // [RULE18]
      else if (hourTick)
        energy <= (energy > DSL_ENERGY_MAX - hourMean) ? DSL_ENERGY_MAX : energy + hourMean; // [RULE3]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cutIns <= 32'h0;
      ovTemps <= 32'h0;
      ovVolts <= 32'h0;
    end
    else
    begin
      if (supplyCutIn)
        cutIns <= satInc(cutIns, DSL_EVENT_MAX); // [RULE4] [RULE22]
      if (overTemp)
        ovTemps <= satInc(ovTemps, DSL_EVENT_MAX); // [RULE5] [RULE22]
      if (ovEvent)
        ovVolts <= satInc(ovVolts, DSL_EVENT_MAX); // [RULE6] [RULE22]
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      DSL_IDLE: next_state = (startCmd & motorRun & ~tripEvt) ? DSL_RUN : DSL_IDLE; // [RULE8]
      DSL_RUN: next_state = (tripEvt | ~motorRun) ? DSL_FROZEN : DSL_RUN; // [RULE9]
      DSL_FROZEN: next_state = (startCmd & motorRun & ~tripEvt) ? DSL_RUN : DSL_FROZEN;
      default: next_state = DSL_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state <= DSL_IDLE;
      logging <= 1'b0;
    end
    else
    begin
      state <= next_state;
      logging <= (next_state == DSL_RUN);
    end
  end

  // Snapshot shift register; index 1 is element 0
  genvar gi;
  generate
    for (gi = 0; gi < LOG_DEPTH; gi++)
    begin : g_log
      always_ff @(posedge ref_clk)
      begin
        if (srst)
          logMem[gi] <= '0;
        else if (capture & ~tripEvt & motorRun)
          logMem[gi] <= (gi == 0) ? dsl_entry_t'({sample, cmdWord}) : logMem[(gi == 0) ? 0 : gi - 1]; // [RULE7] [RULE8] [RULE10] [RULE12] [RULE13]
      end
    end
    for (gi = 0; gi < TRIP_DEPTH; gi++)
    begin : g_trip
      always_ff @(posedge ref_clk)
      begin
        if (srst)
          tripMem[gi] <= '0;
        else if (tripEvt)
          tripMem[gi] <= (gi == 0) ? dsl_trip_t'({codeSat, runHours, valSat}) : tripMem[(gi == 0) ? 0 : gi - 1]; // [RULE14] [RULE15] [RULE16]
        else if (manualInit)
          tripMem[gi] <= '0; // [RULE17]
      end
    end
  endgenerate

  wire logStored = capture & ~tripEvt & motorRun;

  chk_ovolt_gate: assert property (@(posedge ref_clk) disable iff (srst) // [RULE6]
    overVolt && (alarmActive != DSL_OVOLT_ALARM) |=> $stable(ovVolts))
    else $error("over-voltage counted without alarm 7");
  chk_cutin_sat: assert property (@(posedge ref_clk) disable iff (srst) // [RULE22]
    cutIns <= DSL_EVENT_MAX && ovTemps <= DSL_EVENT_MAX && ovVolts <= DSL_EVENT_MAX)
    else $error("event counter beyond 9999");
  chk_cutin_count: assert property (@(posedge ref_clk) disable iff (srst) // [RULE4]
    supplyCutIn && cutIns < DSL_EVENT_MAX |=> cutIns == $past(cutIns) + 32'h1)
    else $error("cut-in not counted");
  chk_ophours_mono: assert property (@(posedge ref_clk) disable iff (srst) // [RULE1]
    ##1 opHours >= $past(opHours))
    else $error("powered hours went down");
  chk_energy_clear: assert property (@(posedge ref_clk) disable iff (srst) // [RULE18]
    panelOk && energySel && !hourTick |=> energy == 32'h0 ##1 !energySel)
    else $error("energy not cleared on confirm");
  chk_run_clear: assert property (@(posedge ref_clk) disable iff (srst) // [RULE21]
    panelOk && runSel |=> runHours <= 32'h1)
    else $error("run hours not cleared on confirm");
  chk_serial_sel: assert property (@(posedge ref_clk) disable iff (srst) // [RULE19]
    !panelSelWr && !panelOk |=> $stable(energySel))
    else $error("energy clear select changed without panel");
  chk_log_shift: assert property (@(posedge ref_clk) disable iff (srst) // [RULE8]
    logStored |=> logMem[1] == $past(logMem[0]) && logMem[0].cmdWord == $past(cmdWord))
    else $error("snapshot log did not shift");
  chk_log_freeze: assert property (@(posedge ref_clk) disable iff (srst) // [RULE9]
    state == DSL_RUN && tripEvt |=> state == DSL_FROZEN && !logging ##1 $stable(logMem[0]))
    else $error("snapshot log not frozen on trip");
  chk_trip_store: assert property (@(posedge ref_clk) disable iff (srst) // [RULE15]
    tripEvt |=> tripMem[0].runHours == $past(runHours) && tripMem[0].code <= DSL_CODE_MAX)
    else $error("trip entry wrong");
  chk_trip_init: assert property (@(posedge ref_clk) disable iff (srst) // [RULE17]
    !manualInit && !tripEvt |=> $stable(tripMem[0]))
    else $error("trip history changed without trip or init");
  chk_bus_okay: assert property (@(posedge ref_clk) disable iff (srst)
    aRd |-> hreadyout && !hresp && hrdata == $past(busRead))
    else $error("read data not from address phase");
endmodule
`default_nettype wire

//--- tb/dsl_panel_model.sv
// Operator panel model: clear-select keys, confirm key and display address.
// Assumes its tasks are called from the bench's main sequence, one key action at a time.
`default_nettype none
module dsl_panel_model (
  input wire logic ref_clk,
  output logic panelSelWr,
  output logic panelSelRun,
  output logic panelSelVal,
  output logic panelOk,
  output logic [7:0] panelAddr,
  output logic [4:0] panelLogIdx,
  output logic [3:0] panelTripIdx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {panelSelWr, panelSelRun, panelSelVal, panelOk} = 4'h0;
    panelAddr = 8'h00;
    panelLogIdx = 5'h01;
    panelTripIdx = 4'h1;
  end
  // Select is a key press of its own, so a confirm acts only on an earlier select
  task automatic keys(input logic wrSel, input logic runSel, input logic val);
    @(posedge ref_clk);
    panelSelWr <= wrSel;
    panelSelRun <= runSel;
    panelSelVal <= val;
    @(posedge ref_clk);
    panelSelWr <= 1'b0;
    panelOk <= 1'b1;
    @(posedge ref_clk);
    panelOk <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic show(input logic [7:0] a);
    @(posedge ref_clk);
    panelAddr <= a;
  endtask
endmodule
`default_nettype wire

//--- tb/dsl_logger_tb.sv
// Self-checking bench for the service-data logger: bus accesses, event pulses, panel keys.
// Assumes a shortened time base: 4 cycles a base tick, 3 base ticks a tenth of an hour.
`default_nettype none
module dsl_logger_tb
  import dsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam dsl_sample_t SA = {8'h28, 16'hbeef, 7'h32, 32'h0001e240, 16'h01f4, 16'h0190, 16'h0064, 16'h0258};
  localparam dsl_sample_t SB = {8'h81, 16'h4321, 7'h64, 32'hfff0bdc0, 16'h270f, 16'h03e8, 16'h0001, 16'h0123};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, motorRun = 1'b1, hready, hreadyout, hresp, nvSave, logging;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, panelData, v0, v1, v2;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2, alarmActive = 3'h0;
  logic [6:0] evts = '0, tripCodeIn = '0;
  logic [13:0] tripValueIn = '0;
  logic [15:0] outPowerW = 16'h03e8, cmdWordOut;
  dsl_sample_t smp = '0;
  logic panelSelWr, panelSelRun, panelSelVal, panelOk;
  logic [7:0] panelAddr;
  logic [4:0] panelLogIdx;
  logic [3:0] panelTripIdx;
  int err_total = 0, comparisons = 0, edg = 0;
  assign hready = hreadyout;
  always #10 ref_clk = ~ref_clk;
  dsl_logger #(.BASE_CYCLES(4), .TENTH_TICKS(3)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .motorRun(motorRun), .startCmd(evts[5]), .powerFail(evts[4]), .supplyCutIn(evts[0]), .overTemp(evts[1]),
    .overVolt(evts[2]), .alarmActive(alarmActive), .outPowerW(outPowerW), .sample(smp), .tripEvt(evts[3]),
    .tripCodeIn(tripCodeIn), .tripValueIn(tripValueIn), .manualInit(evts[6]), .panelSelWr(panelSelWr),
    .panelSelRun(panelSelRun), .panelSelVal(panelSelVal), .panelOk(panelOk), .panelAddr(panelAddr),
    .panelLogIdx(panelLogIdx), .panelTripIdx(panelTripIdx), .panelData(panelData), .cmdWordOut(cmdWordOut),
    .nvSave(nvSave), .logging(logging));
  dsl_panel_model u_pm (
    .ref_clk(ref_clk), .panelSelWr(panelSelWr), .panelSelRun(panelSelRun), .panelSelVal(panelSelVal),
    .panelOk(panelOk), .panelAddr(panelAddr), .panelLogIdx(panelLogIdx), .panelTripIdx(panelTripIdx));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready and read data are sampled mid-cycle, so the value taken is the one the edge will see
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    int n;
    r = 1'b0;
    n = 0;
    while (r !== 1'b1)
    begin
      @(negedge ref_clk);
      r = hreadyout;
      d = hrdata;
      @(posedge ref_clk);
      edg++;
      n++;
      if (n > 50)
      begin
        err_total++;
        end_of_test();
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    edg++;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, '0, v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, '0, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask
  // Bit 0 cut-in, 1 over-temperature, 2 over-voltage, 3 trip, 4 power loss, 5 start, 6 manual init
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      evts <= 7'h01 << which;
      @(posedge ref_clk);
      evts <= '0;
    end
  endtask
  // Equal spacing of first and second reads makes the tick count exact whatever the phase
  task automatic window(input logic [31:0] dp, input logic [31:0] dr, input logic [31:0] de);
    logic [31:0] p, r, e;
    edg = 0;
    rd(DSL_R_OPHOURS, p);
    rd(DSL_R_RUNHOURS, r);
    rd(DSL_R_ENERGY, e);
    repeat (240 - edg) @(posedge ref_clk);
    rdchk(DSL_R_OPHOURS, p + dp);
    rdchk(DSL_R_RUNHOURS, r + dr);
    rdchk(DSL_R_ENERGY, e + de);
  endtask
  function automatic logic [31:0] fld(input dsl_sample_t s, input int i);
    case (i)
      0: return {24'h0, s.digIn};
      1: return 32'h1234;
      2: return {16'h0, s.stateWord};
      3: return {25'h0, s.refPct};
      4: return s.feedback;
      5: return {16'h0, s.outFreq};
      6: return {16'h0, s.outVolt};
      7: return {16'h0, s.outCurr};
      default: return {16'h0, s.dcLink};
    endcase
  endfunction
  task automatic logchk(input logic [4:0] idx, input dsl_sample_t s);
    wr(DSL_R_LOGIDX, {27'h0, idx});
    for (int i = 0; i < 9; i++)
      rdchk(DSL_R_LOG_INP + 8'(4 * i), fld(s, i));
  endtask
  task automatic tripchk(input logic [3:0] idx, input logic [31:0] c, input logic [31:0] t, input logic [31:0] v);
    wr(DSL_R_TRIPIDX, {28'h0, idx});
    rdchk(DSL_R_TRIP_CODE, c);
    rdchk(DSL_R_TRIP_TIME, t);
    rdchk(DSL_R_TRIP_VAL, v);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rdchk(DSL_R_ENERGY, 32'h0);
    rdchk(DSL_R_CUTINS, 32'h0);
    rdchk(DSL_R_LOGIDX, 32'h1);
    rdchk(DSL_R_TRIPIDX, 32'h1);
    rdchk(8'hfc, 32'h0);
    window(32'd20, 32'd20, 32'd2000);
    motorRun <= 1'b0;
    outPowerW <= 16'h0000;
    repeat (260) @(posedge ref_clk);
    window(32'd20, 32'd0, 32'd0);
    rd(DSL_R_ENERGY, v0);
    wr(DSL_R_CLRSEL, 32'h3);
    rdchk(DSL_R_CLRSEL, 32'h0);
    u_pm.keys(1'b0, 1'b0, 1'b0);
    rdchk(DSL_R_ENERGY, v0);
    u_pm.keys(1'b1, 1'b0, 1'b0);
    rdchk(DSL_R_ENERGY, v0);
    rd(DSL_R_RUNHOURS, v1);
    u_pm.keys(1'b1, 1'b0, 1'b1);
    rdchk(DSL_R_ENERGY, 32'h0);
    rdchk(DSL_R_RUNHOURS, v1);
    u_pm.keys(1'b1, 1'b1, 1'b1);
    rdchk(DSL_R_RUNHOURS, 32'h0);
    rd(DSL_R_OPHOURS, v2);
    chk("powered hours kept", 32'h1, {31'h0, v2 > 32'd40});
    pulse(0, 3);
    pulse(1, 2);
    alarmActive <= DSL_OVOLT_ALARM;
    pulse(2, 2);
    alarmActive <= 3'h6;
    pulse(2, 1);
    rdchk(DSL_R_CUTINS, 32'd3);
    rdchk(DSL_R_OVTEMPS, 32'd2);
    rdchk(DSL_R_OVVOLTS, 32'd2);
    pulse(0, 9998);
    rdchk(DSL_R_CUTINS, 32'd9999);
    u_pm.show(DSL_R_CUTINS);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("panel data", 32'd9999, panelData);
    pulse(4, 1);
    @(negedge ref_clk);
    chk("save request", 32'h1, {31'h0, nvSave});
    wr(DSL_R_CMDWORD, 32'h1234);
    rdchk(DSL_R_CMDWORD, 32'h1234);
    chk("command out", 32'h1234, {16'h0, cmdWordOut});
    smp <= SA;
    motorRun <= 1'b1;
    pulse(5, 1);
    rdchk(DSL_R_STATUS, 32'h1);
    chk("logging", 32'h1, {31'h0, logging});
    repeat (1400) @(posedge ref_clk);
    smp <= SB;
    repeat (192) @(posedge ref_clk);
    motorRun <= 1'b0;
    smp <= ~SB;
    repeat (200) @(posedge ref_clk);
    rdchk(DSL_R_STATUS, 32'h3);
    chk("logging", 32'h0, {31'h0, logging});
    logchk(5'd1, SB);
    logchk(5'd2, SB);
    logchk(5'd5, SA);
    logchk(5'd20, SA);
    wr(DSL_R_LOGIDX, 32'd21);
    rdchk(DSL_R_LOGIDX, 32'd20);
    rd(DSL_R_RUNHOURS, v1);
    for (int i = 1; i <= 11; i++)
    begin
      tripCodeIn <= 7'(i);
      tripValueIn <= 14'(100 * i);
      pulse(3, 1);
    end
    tripCodeIn <= 7'h7f;
    tripValueIn <= 14'h3fff;
    pulse(3, 1);
    tripchk(4'd1, 32'd99, v1, 32'd9999);
    tripchk(4'd2, 32'd11, v1, 32'd1100);
    tripchk(4'd10, 32'd3, v1, 32'd300);
    wr(DSL_R_TRIPIDX, 32'd11);
    rdchk(DSL_R_TRIPIDX, 32'd10);
    u_pm.keys(1'b1, 1'b0, 1'b1);
    tripchk(4'd1, 32'd99, v1, 32'd9999);
    pulse(6, 1);
    tripchk(4'd1, 32'd0, 32'd0, 32'd0);
    motorRun <= 1'b1;
    pulse(5, 1);
    pulse(3, 1);
    rdchk(DSL_R_STATUS, 32'h3);
    chk("logging", 32'h0, {31'h0, logging});
    end_of_test();
  end
endmodule
`default_nettype wire
